// *** design/srw_pkg.sv ***
package srw_pkg;

   // data and field widths
   localparam int WORD_W = 32;
   localparam int SHAMT_W = 5;
   localparam int GPR_IDX_W = 5;
   localparam int CR_FIELD_W = 4;
   localparam int CNT_W = 16;
   localparam int ADDR_W = 8;

   // instruction fields, bit 0 of the manual is the msb here
   localparam int F_PRI_HI = 31;
   localparam int F_PRI_LO = 26;
   localparam int F_SRC_HI = 25;
   localparam int F_SRC_LO = 21;
   localparam int F_DST_HI = 20;
   localparam int F_DST_LO = 16;
   localparam int F_AMT_HI = 15;
   localparam int F_AMT_LO = 11;
   localparam int F_XO_HI = 10;
   localparam int F_XO_LO = 1;
   localparam int F_REC = 0;

   localparam logic [5:0] OPC_PRIMARY = 6'h1F;
   // 792 register amount, 824 immediate amount
   localparam logic [9:0] XO_SHIFT_REG = 10'h318;
   localparam logic [9:0] XO_SHIFT_IMM = 10'h338;

   // amount register: count in bits 27-31, mask select in bit 26
   localparam int AMT_CNT_HI = 4;
   localparam int AMT_CNT_LO = 0;
   localparam int AMT_ZMASK_BIT = 5;
   localparam int SIGN_BIT = 31;

   // condition field 0 layout
   localparam int CR_NEG = 3;
   localparam int CR_POS = 2;
   localparam int CR_ZERO = 1;
   localparam int CR_SO = 0;

   // register map (byte addresses)
   localparam logic [7:0] REG_XER = 8'h00;
   localparam logic [7:0] REG_CR0 = 8'h04;
   localparam logic [7:0] REG_RESULT = 8'h08;
   localparam logic [7:0] REG_COUNT = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;

   // fixed-point exception register bits and status register illegal bit
   localparam int XER_CA = 0;
   localparam int XER_SO = 1;
   localparam int STAT_ILLEGAL = 0;

   localparam logic [31:0] WORD_ONES = 32'hFFFFFFFF;
   localparam logic [31:0] WORD_ZERO = 32'h00000000;

   typedef enum logic [1:0] {
      SRW_OP_NONE,
      SRW_OP_REG,
      SRW_OP_IMM
   } srw_op_t;

endpackage

// *** design/srw_unit.sv ***
// Function
// - decode primary 31 and extended 792 as register-amount form with record bit.
// - decode primary 31 and extended 824 as immediate form, distance in 16-20.
// - legacy alias mnemonics share encodings and behaviour with the word shifts.
// - register form counts from amount bits 27-31, rotates left by 32 minus N.
// - sign word replicates source sign bit across all 32 positions.
// - register form mask is N zeros then ones, all zeros when bit 26 set.
// - result takes rotated bits where mask is one, sign bits elsewhere.
// - carry is or of rotated and inverted mask, anded with source sign.
// - every form updates the carry flag; no overflow-enable behaviour exists.
// - record bit set updates negative, positive, zero and summary bits.
// - immediate form takes N from the immediate distance field.
// - immediate form always uses N zeros followed by ones as mask.
`timescale 1ns/1ns
`default_nettype none

module srw_unit
   import srw_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic issue_valid,
   input wire logic [WORD_W-1:0] instr,
   input wire logic [WORD_W-1:0] source_gpr,
   input wire logic [WORD_W-1:0] amount_gpr,
   output logic issue_ready,
   output logic wb_valid,
   output logic [GPR_IDX_W-1:0] wb_dest_gpr,
   output logic [WORD_W-1:0] wb_data,
   output logic carry_flag,
   output logic summary_ovf,
   output logic cr0_we,
   output logic [CR_FIELD_W-1:0] cr0,
   output logic illegal,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [WORD_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [WORD_W-1:0] reg_rdata
);

   ////////////////////////////////////////////////////////////////////////

   typedef struct packed {
      logic wb_valid;
      logic [GPR_IDX_W-1:0] wb_dest;
      logic [WORD_W-1:0] wb_data;
      logic cr0_we;
      logic [CR_FIELD_W-1:0] cr0;
      logic carry;
      logic so;
      logic illegal;
      logic illegal_sticky;
      logic [CNT_W-1:0] op_count;
      logic [WORD_W-1:0] rdata;
   } srw_state_t;

   srw_state_t st_q;
   srw_state_t st_d;

   ////////////////////////////////////////////////////////////////////////

   function automatic srw_op_t decode_op(input logic [WORD_W-1:0] ins);
      srw_op_t op;
      op = SRW_OP_NONE;
      // aliases carry the same bits, so one decode serves both names
      if (ins[F_PRI_HI:F_PRI_LO] == OPC_PRIMARY) begin
         if (ins[F_XO_HI:F_XO_LO] == XO_SHIFT_REG) begin
            op = SRW_OP_REG;
         end else if (ins[F_XO_HI:F_XO_LO] == XO_SHIFT_IMM) begin
            op = SRW_OP_IMM;
         end
      end
      return op;
   endfunction

   // rotate left by 32-N is the same as rotate right by N
   function automatic logic [WORD_W-1:0] rot_left_comp(
      input logic [WORD_W-1:0] w,
      input logic [SHAMT_W-1:0] n
   );
      logic [2*WORD_W-1:0] dbl;
      dbl = {w, w} >> n;
      return dbl[WORD_W-1:0];
   endfunction

   function automatic logic [WORD_W-1:0] mask_gen(
      input logic [SHAMT_W-1:0] n,
      input logic all_zero
   );
      logic [WORD_W-1:0] m;
      m = WORD_ONES >> n;
      if (all_zero) begin
         m = WORD_ZERO;
      end
      return m;
   endfunction

   function automatic logic [CR_FIELD_W-1:0] cr_from(
      input logic [WORD_W-1:0] r,
      input logic so
   );
      logic [CR_FIELD_W-1:0] c;
      c = '0;
      c[CR_NEG] = r[SIGN_BIT];
      c[CR_POS] = ~r[SIGN_BIT] & (|r);
      c[CR_ZERO] = ~(|r);
      c[CR_SO] = so;
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // datapath, purely combinational in the issue cycle

   srw_op_t op;
   logic fire;
   logic [SHAMT_W-1:0] shamt;
   logic zmask;
   logic [WORD_W-1:0] rotated;
   logic [WORD_W-1:0] sign_word;
   logic [WORD_W-1:0] mask;
   logic [WORD_W-1:0] merged;
   logic carry_out;
   logic so_now;

   always_comb begin
      op = decode_op(instr);
      fire = issue_valid && (op != SRW_OP_NONE);
      if (op == SRW_OP_IMM) begin
         shamt = instr[F_AMT_HI:F_AMT_LO];
         zmask = 1'b0;
      end else begin
         shamt = amount_gpr[AMT_CNT_HI:AMT_CNT_LO];
         zmask = amount_gpr[AMT_ZMASK_BIT];
      end
      rotated = rot_left_comp(source_gpr, shamt);
      sign_word = {WORD_W{source_gpr[SIGN_BIT]}};
      mask = mask_gen(shamt, zmask);
      merged = (rotated & mask) | (sign_word & ~mask);
      // only ones shifted out of a negative word raise carry
      carry_out = (|(rotated & ~mask)) & source_gpr[SIGN_BIT];
      // a software write to the summary bit in this cycle is seen at once
      so_now = st_q.so;
      if (reg_wr && reg_addr == REG_XER) begin
         so_now = reg_wdata[XER_SO];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_d = st_q;
      st_d.wb_valid = fire;
      st_d.cr0_we = 1'b0;
      st_d.illegal = issue_valid && (op == SRW_OP_NONE);
      st_d.rdata = WORD_ZERO;

      // software writes to the exception flags and the op counter
      if (reg_wr) begin
         case (reg_addr)
            REG_XER: begin
               st_d.carry = reg_wdata[XER_CA];
               st_d.so = reg_wdata[XER_SO];
            end
            REG_STATUS: begin
               if (reg_wdata[STAT_ILLEGAL]) begin
                  st_d.illegal_sticky = 1'b0;
               end
            end
            REG_COUNT: begin
               st_d.op_count = '0;
            end
            default: begin
            end
         endcase
      end

      // the unit's own update wins over a same-cycle software write
      if (fire) begin
         st_d.wb_dest = instr[F_DST_HI:F_DST_LO];
         st_d.wb_data = merged;
         st_d.carry = carry_out;
         st_d.op_count = st_q.op_count + 1'b1;
         if (instr[F_REC]) begin
            st_d.cr0_we = 1'b1;
            st_d.cr0 = cr_from(merged, so_now);
         end
      end
      if (st_d.illegal) begin
         st_d.illegal_sticky = 1'b1;
      end

      if (reg_rd) begin
         case (reg_addr)
            REG_XER: begin
               st_d.rdata[XER_CA] = st_q.carry;
               st_d.rdata[XER_SO] = st_q.so;
            end
            REG_CR0: st_d.rdata[CR_FIELD_W-1:0] = st_q.cr0;
            REG_RESULT: st_d.rdata = st_q.wb_data;
            REG_COUNT: st_d.rdata[CNT_W-1:0] = st_q.op_count;
            REG_STATUS: st_d.rdata[STAT_ILLEGAL] = st_q.illegal_sticky;
            default: st_d.rdata = WORD_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////

   // single-cycle datapath, never stalls decode
   assign issue_ready = 1'b1;
   assign wb_valid = st_q.wb_valid;
   assign wb_dest_gpr = st_q.wb_dest;
   assign wb_data = st_q.wb_data;
   assign carry_flag = st_q.carry;
   assign summary_ovf = st_q.so;
   assign cr0_we = st_q.cr0_we;
   assign cr0 = st_q.cr0;
   assign illegal = st_q.illegal;
   assign reg_rdata = st_q.rdata;

endmodule

`default_nettype wire

// *** verification/srw_unit_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module srw_unit_asserts
   import srw_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic issue_valid,
   input wire logic [WORD_W-1:0] instr,
   input wire logic [WORD_W-1:0] source_gpr,
   input wire logic [WORD_W-1:0] amount_gpr,
   input wire logic wb_valid,
   input wire logic [GPR_IDX_W-1:0] wb_dest_gpr,
   input wire logic [WORD_W-1:0] wb_data,
   input wire logic carry_flag,
   input wire logic cr0_we,
   input wire logic [CR_FIELD_W-1:0] cr0,
   input wire logic illegal
);
   wire pri = issue_valid && instr[31:26] == OPC_PRIMARY;
   wire reg_f = pri && instr[10:1] == XO_SHIFT_REG;
   wire imm_f = pri && instr[10:1] == XO_SHIFT_IMM;
   wire go = reg_f || imm_f;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_wb; wb_valid && !illegal; endsequence
   sequence s_bad; illegal && !wb_valid && !cr0_we; endsequence
   property p_answer; go |=> s_wb; endproperty
   a_answer: assert property (p_answer) else $error("no write-back");
   property p_refuse; issue_valid && !go |=> s_bad; endproperty
   a_refuse: assert property (p_refuse) else $error("bad op taken");
   property p_rec; go |=> cr0_we == $past(instr[0]); endproperty
   a_rec: assert property (p_rec) else $error("record pulse");
   property p_dst; go |=> wb_dest_gpr == $past(instr[20:16]); endproperty
   a_dst: assert property (p_dst) else $error("dest index");
   property p_zmask;
      reg_f && amount_gpr[5] |=> wb_data == {32{$past(source_gpr[31])}};
   endproperty
   a_zmask: assert property (p_zmask) else $error("zero mask");
   property p_imm0;
      imm_f && instr[15:11] == 5'h0 |=> wb_data == $past(source_gpr);
   endproperty
   a_imm0: assert property (p_imm0) else $error("shift zero");
   property p_carry; go && !source_gpr[31] |=> !carry_flag; endproperty
   a_carry: assert property (p_carry) else $error("carry set");
   property p_cr;
      cr0_we |-> cr0[3] == wb_data[31] && cr0[1] == (wb_data == '0)
         && cr0[2] == !(wb_data[31] || wb_data == '0);
   endproperty
   a_cr: assert property (p_cr) else $error("field 0");
   // no write-back pulse now means no op was taken at the previous edge
   property p_hold; !wb_valid |-> $stable(wb_data); endproperty
   a_hold: assert property (p_hold) else $error("result moved");
endmodule
bind srw_unit srw_unit_asserts chk (.*);
`default_nettype wire

// *** verification/srw_gpr_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module srw_gpr_model
   import srw_pkg::*;
(
   input wire logic [WORD_W-1:0] instr,
   output logic [WORD_W-1:0] source_gpr,
   output logic [WORD_W-1:0] amount_gpr
);
   // cleared so operands are never unknown before the first load
   logic [WORD_W-1:0] gpr [32] = '{default: '0};
   assign source_gpr = gpr[instr[F_SRC_HI:F_SRC_LO]];
   assign amount_gpr = gpr[instr[F_AMT_HI:F_AMT_LO]];
endmodule
`default_nettype wire

// *** verification/srw_unit_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module srw_unit_tb_top
   import srw_pkg::*;
;
   logic clk = 1'h0, reset = 1'h1, issue_valid = 1'h0;
   logic reg_wr = 1'h0, reg_rd = 1'h0;
   logic [WORD_W-1:0] instr = '0, reg_wdata = '0;
   logic [WORD_W-1:0] source_gpr, amount_gpr, reg_rdata, wb_data;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [GPR_IDX_W-1:0] wb_dest_gpr;
   logic [CR_FIELD_W-1:0] cr0;
   logic issue_ready, wb_valid, carry_flag, summary_ovf, cr0_we, illegal;
   logic [9:0] xr = XO_SHIFT_REG, xi = XO_SHIFT_IMM;
   int n_fail = 0, comparisons = 0, cyc = 0;
   always #20 clk = ~clk;
   srw_gpr_model gm (.*);
   srw_unit uut (.*);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(string what, logic [31:0] e, logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 chk("reg_rdata", e, reg_rdata);
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask
   // immediate form reuses the low amount bits as its distance field
   task automatic op(logic [9:0] xo, logic rc, logic [31:0] s, a);
      gm.gpr[4] = s;
      gm.gpr[5] = a;
      @(posedge clk);
      issue_valid <= 1'h1;
      instr <= {OPC_PRIMARY, 5'h4, 5'h6, xo == xi ? a[4:0] : 5'h5, xo, rc};
      @(posedge clk);
      issue_valid <= 1'h0;
      #1;
   endtask
   task automatic ts(logic [9:0] xo, logic rc, logic [31:0] s, a, ed,
      logic ec, logic [3:0] ecr);
      op(xo, rc, s, a);
      chk("wb_valid", 1'h1, wb_valid);
      chk("wb_dest_gpr", 5'h6, wb_dest_gpr);
      chk("wb_data", ed, wb_data);
      chk("carry_flag", ec, carry_flag);
      chk("cr0_we", rc, cr0_we);
      if (rc) chk("cr0", ecr, cr0);
      $display("shift case done");
   endtask
   task automatic t_refuse();
      op(10'h3B8, 1'h1, 32'h1, 6'h4);
      chk("illegal", 1'h1, illegal);
      chk("wb_valid", 1'h0, wb_valid);
      chk("carry_flag", 1'h1, carry_flag);
      chk("cr0", 4'h9, cr0);
      rd(REG_STATUS, 32'h1);
      rd(8'h14, 32'h0);
      rd(REG_RESULT, 32'hF9000300);
      $display("refuse case done");
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 400) begin
         n_fail++;
         report_and_stop();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'h0;
      rd(REG_XER, 32'h0);
      ts(xr, 1'h0, 32'h90003000, 6'h24, 32'hFFFFFFFF, 1'h1, 4'h0);
      ts(xr, 1'h0, 32'h90003000, 6'h04, 32'hF9000300, 1'h0, 4'h0);
      ts(xr, 1'h1, 32'hB0043000, 6'h04, 32'hFB004300, 1'h0, 4'h8);
      ts(xr, 1'h1, 32'h7FFFFFFF, 6'h1F, 32'h00000000, 1'h0, 4'h2);
      ts(xi, 1'h1, 32'hB0043000, 6'h24, 32'hFB004300, 1'h0, 4'h8);
      ts(xi, 1'h0, 32'h9000300F, 6'h04, 32'hF9000300, 1'h1, 4'h0);
      ts(xi, 1'h1, 32'h12345678, 6'h00, 32'h12345678, 1'h0, 4'h4);
      wr(REG_XER, 32'h2);
      ts(xr, 1'h1, 32'h9000300F, 6'h04, 32'hF9000300, 1'h1, 4'h9);
      chk("summary_ovf", 1'h1, summary_ovf);
      chk("issue_ready", 1'h1, issue_ready);
      rd(REG_XER, 32'h3);
      rd(REG_CR0, 32'h9);
      rd(REG_COUNT, 32'h8);
      wr(REG_COUNT, 32'h0);
      rd(REG_COUNT, 32'h0);
      t_refuse();
      report_and_stop();
   end
endmodule
`default_nettype wire
